// File: design/pmoc_top.sv
// PWM module output control: registers, sync, gating, fault and inversion
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module pmoc_top #(
    parameter int NUM_CH = pmoc_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Generator side
    input wire logic [NUM_CH-1:0] deadband_out,
    input wire logic gen0_zero,
    input wire logic gen0_int,
    output logic gen0_update_apply,
    output logic gen0_counter_reset,
    // External pins and events
    input wire logic fault_pin,
    input wire logic debug_stall,
    output logic fault_condition,
    output logic channel_a_output,
    output logic channel_b_output,
    output logic irq
);
    pmoc_pkg::pmoc_apb_req_t req;
    logic [11:0] off;
    logic in_range, wr_en, rd_en;
    logic gen0_global_update_request_q;
    logic gen0_counter_resync_q;
    logic [NUM_CH-1:0] out_enable_q, invert_q, fault_force_q;
    logic fault_int_en_q, gen0_int_en_q;
    logic fault_int_q;
    logic [1:0] fault_sync_q, stall_sync_q;
    logic fault_level, fault_level_q;
    logic [NUM_CH-1:0] pin_d, pin_q;
    logic [31:0] rdata_d;
    logic [31:0] ris_val, isc_val;

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign off = req.paddr[11:0];
    assign in_range = (req.paddr[31:12] == pmoc_pkg::BASE_ADDR[31:12]);
    assign pready = 1'b1;
    assign wr_en = psel && penable && req.pwrite && in_range;
    assign rd_en = psel && !penable && !req.pwrite;

    // Unmapped or misaligned access flags an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (!in_range || off[1:0] != 2'h0 || off > pmoc_pkg::OFF_STATUS) begin
                pslverr = 1'b1;
            end
        end
    end

    // Input synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_sync_q <= 2'h0;
            stall_sync_q <= 2'h0;
        end else begin
            fault_sync_q <= {fault_sync_q[0], fault_pin};
            stall_sync_q <= {stall_sync_q[0], debug_stall};
        end
    end
    assign fault_level = fault_sync_q[1];
    assign fault_condition = fault_sync_q[1] | stall_sync_q[1];

    // Global update request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen0_global_update_request_q <= 1'b0;
        end else if (wr_en && off == pmoc_pkg::OFF_CTL && req.pwdata[0]) begin
            gen0_global_update_request_q <= 1'b1;
        end else if (gen0_zero) begin
            gen0_global_update_request_q <= 1'b0;
        end
    end
    assign gen0_update_apply = gen0_global_update_request_q && gen0_zero;

    // Counter resync, one cycle then self-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen0_counter_resync_q <= 1'b0;
        end else if (wr_en && off == pmoc_pkg::OFF_SYNC && req.pwdata[0]) begin
            gen0_counter_resync_q <= 1'b1;
        end else begin
            gen0_counter_resync_q <= 1'b0;
        end
    end
    assign gen0_counter_reset = gen0_counter_resync_q;

    // Output control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_enable_q <= '0;
            invert_q <= '0;
            fault_force_q <= '0;
            fault_int_en_q <= 1'b0;
            gen0_int_en_q <= 1'b0;
        end else if (wr_en) begin
            case (off)
                pmoc_pkg::OFF_ENABLE: out_enable_q <= req.pwdata[NUM_CH-1:0];
                pmoc_pkg::OFF_INVERT: invert_q <= req.pwdata[NUM_CH-1:0];
                pmoc_pkg::OFF_FAULT: fault_force_q <= req.pwdata[NUM_CH-1:0];
                pmoc_pkg::OFF_INTEN: begin
                    fault_int_en_q <= req.pwdata[pmoc_pkg::FAULT_INT_BIT];
                    gen0_int_en_q <= req.pwdata[pmoc_pkg::GEN0_INT_BIT];
                end
                default: ;
            endcase
        end
    end

    // Fault interrupt latch; set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_int_q <= 1'b0;
            fault_level_q <= 1'b0;
        end else begin
            fault_level_q <= fault_level;
            if (fault_level && !fault_level_q) begin
                fault_int_q <= 1'b1;
            end else if (wr_en && off == pmoc_pkg::OFF_ISC
                         && req.pwdata[pmoc_pkg::FAULT_INT_BIT]) begin
                fault_int_q <= 1'b0;
            end
        end
    end

    always_comb begin
        ris_val = 32'h0;
        ris_val[pmoc_pkg::FAULT_INT_BIT] = fault_int_q;
        ris_val[pmoc_pkg::GEN0_INT_BIT] = gen0_int;
        isc_val = 32'h0;
        isc_val[pmoc_pkg::FAULT_INT_BIT] = fault_int_q && fault_int_en_q;
        isc_val[pmoc_pkg::GEN0_INT_BIT] = gen0_int && gen0_int_en_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |isc_val;
        end
    end

    // Read data
    always_comb begin
        rdata_d = 32'h0;
        case (off)
            pmoc_pkg::OFF_CTL: rdata_d[0] = gen0_global_update_request_q;
            pmoc_pkg::OFF_SYNC: rdata_d[0] = gen0_counter_resync_q;
            pmoc_pkg::OFF_ENABLE: rdata_d[NUM_CH-1:0] = out_enable_q;
            pmoc_pkg::OFF_INVERT: rdata_d[NUM_CH-1:0] = invert_q;
            pmoc_pkg::OFF_FAULT: rdata_d[NUM_CH-1:0] = fault_force_q;
            pmoc_pkg::OFF_INTEN: begin
                rdata_d[pmoc_pkg::FAULT_INT_BIT] = fault_int_en_q;
                rdata_d[pmoc_pkg::GEN0_INT_BIT] = gen0_int_en_q;
            end
            pmoc_pkg::OFF_RIS: rdata_d = ris_val;
            pmoc_pkg::OFF_ISC: rdata_d = isc_val;
            pmoc_pkg::OFF_STATUS: rdata_d[0] = fault_level;
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= pmoc_pkg::RESET_VALUE;
        end else if (rd_en) begin
            prdata <= in_range ? rdata_d : 32'h0;
        end
    end

    // Per-channel output path
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            logic stage;
            always_comb begin
                stage = deadband_out[i];
                if (fault_condition && fault_force_q[i]) begin
                    stage = 1'b0;
                end
                if (!out_enable_q[i]) begin
                    stage = 1'b0;
                end
                pin_d[i] = stage ^ invert_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= '0;
        end else begin
            pin_q <= pin_d;
        end
    end
    assign channel_a_output = pin_q[0];
    assign channel_b_output = pin_q[1];

    // Assertions
    // Sync write and the one-cycle counter reset that follows it
    sequence s_sync_write;
        wr_en && off == pmoc_pkg::OFF_SYNC && req.pwdata[0];
    endsequence

    sequence s_reset_pulse;
        gen0_counter_reset ##1 !gen0_counter_reset;
    endsequence

    // Software request for a global update
    sequence s_update_set;
        wr_en && off == pmoc_pkg::OFF_CTL && req.pwdata[0];
    endsequence

    // Synchronised fault level going high
    sequence s_fault_rise;
        !fault_level ##1 fault_level;
    endsequence

    a_sync_self_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        gen0_counter_resync_q |=> !gen0_counter_resync_q)
        else $error("counter resync did not self-clear");

    a_sync_on_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_sync_write |=> s_reset_pulse)
        else $error("counter reset missing after sync write");

    a_update_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_update_set |=> gen0_global_update_request_q)
        else $error("global update request not set");

    a_update_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        gen0_update_apply && !(wr_en && off == pmoc_pkg::OFF_CTL)
        |=> !gen0_global_update_request_q)
        else $error("global update did not clear");

    a_update_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        gen0_global_update_request_q && !gen0_zero
        |=> gen0_global_update_request_q)
        else $error("global update lost before zero");

    a_disabled_pin: assert property (
        @(posedge clk) disable iff (!rst_n)
        !out_enable_q[0] |=> channel_a_output == $past(invert_q[0]))
        else $error("disabled channel pin wrong");

    a_disabled_pin_b: assert property (
        @(posedge clk) disable iff (!rst_n)
        !out_enable_q[1] |=> channel_b_output == $past(invert_q[1]))
        else $error("disabled second channel pin wrong");

    a_fault_force: assert property (
        @(posedge clk) disable iff (!rst_n)
        fault_condition && fault_force_q[0]
        |=> channel_a_output == $past(invert_q[0]))
        else $error("fault forcing wrong");

    a_fault_pass: assert property (
        @(posedge clk) disable iff (!rst_n)
        fault_condition && !fault_force_q[1] && out_enable_q[1]
        |=> channel_b_output
            == ($past(deadband_out[1]) ^ $past(invert_q[1])))
        else $error("pass-through channel altered by fault");

    a_fault_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        fault_int_q && !(wr_en && off == pmoc_pkg::OFF_ISC)
        |=> fault_int_q)
        else $error("fault interrupt dropped");

    a_fault_detect: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_fault_rise |=> fault_int_q)
        else $error("fault interrupt not latched");

    a_isc_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_en && off == pmoc_pkg::OFF_ISC
        && req.pwdata[pmoc_pkg::FAULT_INT_BIT]
        && !(fault_level && !fault_level_q)
        |=> !fault_int_q)
        else $error("fault interrupt not cleared");

    a_irq_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        fault_int_q && fault_int_en_q |=> irq)
        else $error("irq not raised");

    a_irq_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(fault_int_q && fault_int_en_q) && !(gen0_int && gen0_int_en_q)
        |=> !irq)
        else $error("irq raised with no unmasked status");

    a_fault_cond: assert property (
        @(posedge clk) disable iff (!rst_n)
        fault_sync_q[1] |-> fault_condition)
        else $error("fault input not a fault condition");

    a_stall_fault: assert property (
        @(posedge clk) disable iff (!rst_n)
        stall_sync_q[1] |-> fault_condition)
        else $error("debug stall not a fault condition");

    a_status_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_en && in_range && off == pmoc_pkg::OFF_STATUS
        |=> prdata == {31'h0, $past(fault_level)})
        else $error("fault status read wrong");

    a_bad_offset: assert property (
        @(posedge clk) disable iff (!rst_n)
        psel && penable && off > pmoc_pkg::OFF_STATUS |-> pslverr)
        else $error("unmapped offset not refused");

    a_enabled_pass: assert property (
        @(posedge clk) disable iff (!rst_n)
        out_enable_q[0] && !fault_condition
        |=> channel_a_output
            == ($past(deadband_out[0]) ^ $past(invert_q[0])))
        else $error("enabled channel not passing");

    a_enabled_pass_b: assert property (
        @(posedge clk) disable iff (!rst_n)
        out_enable_q[1] && !fault_condition
        |=> channel_b_output
            == ($past(deadband_out[1]) ^ $past(invert_q[1])))
        else $error("enabled second channel not passing");

endmodule

// File: inc/pmoc_pkg.sv
// Constants and types of the PWM module output control block
// Operation
// - Global update bit applies queued load/compare updates at next counter zero
// - Global update bit self-clears after updates apply; software zero ignored
// - Writing one to counter-sync bit resets that counter; bits act together
// - Counter-sync bit self-clears after the reset; zero means done
// - Enabled channel passes generated signal; disabled channel passes zero
// - Disabling an output never stops generation or time bases
// - Inversion bit inverts channel at pin; clear means active high
// - Inverter also acts on disabled channels
// - Fault input and debugger stall both count as fault conditions
// - During fault, channels with fault bit forced low, others pass
// - Fault forcing precedes inverter, so inverted forced channel drives high
// - Pass-through generation during fault follows generator debug setting
// - Registers decode as offsets from a fixed module base
// - Fault status register reports present fault input level
// - Status-and-clear readable, write-one clears; raw status read-only
// - Fault input raises module interrupt when enable bit 16 set
// - Fault interrupt status latched until software writes one to clear
package pmoc_pkg;
    localparam logic [31:0] BASE_ADDR = 32'h4002_8000;
    localparam logic [11:0] OFF_CTL = 12'h000;
    localparam logic [11:0] OFF_SYNC = 12'h004;
    localparam logic [11:0] OFF_ENABLE = 12'h008;
    localparam logic [11:0] OFF_INVERT = 12'h00c;
    localparam logic [11:0] OFF_FAULT = 12'h010;
    localparam logic [11:0] OFF_INTEN = 12'h014;
    localparam logic [11:0] OFF_RIS = 12'h018;
    localparam logic [11:0] OFF_ISC = 12'h01c;
    localparam logic [11:0] OFF_STATUS = 12'h020;
    localparam int FAULT_INT_BIT = 16;
    localparam int GEN0_INT_BIT = 0;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam int NUM_CH = 2;

    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } pmoc_apb_req_t;
endpackage

// File: verification/pmoc_power_stage.sv
// Power stage model: reports a trip on the fault line
`timescale 1ns/1ps
module pmoc_power_stage (
    // Gate drive from the pins
    input wire logic high_side,
    input wire logic low_side,
    // Trip command and fault report
    input wire logic trip,
    output logic fault_pin
);
    // Fault line is always driven, active high
    assign fault_pin = trip;
endmodule

// File: verification/pwm_module_output_control_test.sv
// Self-checking bench for the PWM output control block
`timescale 1ns/1ps
module pwm_module_output_control_test;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic pready, pslverr, err, gen0_zero = 0, gen0_int = 0, trip = 0;
    logic debug_stall = 0, fault_pin, fault_cond, apply, cnt_rst;
    logic pin_a, pin_b, irq;
    logic [1:0] db = '0;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    pmoc_top u_pmoc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .deadband_out(db), .gen0_zero(gen0_zero),
        .gen0_int(gen0_int), .gen0_update_apply(apply),
        .gen0_counter_reset(cnt_rst), .fault_pin(fault_pin),
        .debug_stall(debug_stall), .fault_condition(fault_cond),
        .channel_a_output(pin_a), .channel_b_output(pin_b), .irq(irq));
    pmoc_power_stage u_pmoc_power_stage (.high_side(pin_a),
        .low_side(pin_b), .trip(trip), .fault_pin(fault_pin));
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Writes the full 32-bit d; the bench also writes bit 16 and unmapped offset 0x024
    task automatic apb(input logic w, input logic [11:0] off,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= pmoc_pkg::BASE_ADDR + {20'h0, off};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [11:0] off,
                        input logic [31:0] exp);
        apb(1'b0, off, '0);
        chk(nm, rd, exp);
    endtask
    task automatic pins(input logic [1:0] exp);
        repeat (4) @(posedge clk);
        chk("pins", {30'h0, pin_b, pin_a}, {30'h0, exp});
    endtask
    task automatic zero(input logic exp);
        @(posedge clk);
        gen0_zero <= 1'b1;
        #1 chk("apply", apply, exp);
        @(posedge clk);
        gen0_zero <= 1'b0;
    endtask
    task automatic t_reset;
        for (int i = 0; i <= 8; i++)
            rchk("reset", 12'(i * 4), '0);
    endtask
    task automatic t_bus;
        apb(1'b1, 12'h024, 32'h1);
        chk("slverr", err, 1'b1);
        rchk("unmapped", 12'h024, '0);
        apb(1'b1, pmoc_pkg::OFF_RIS, 32'h0001_0001);
        rchk("raw ro", pmoc_pkg::OFF_RIS, '0);
        gen0_int <= 1'b1;
        rchk("raw gen", pmoc_pkg::OFF_RIS, 32'h1);
        apb(1'b1, pmoc_pkg::OFF_INTEN, 32'h1);
        rchk("isc gen", pmoc_pkg::OFF_ISC, 32'h1);
        chk("irq gen", irq, 1'b1);
        gen0_int <= 1'b0;
        apb(1'b1, pmoc_pkg::OFF_INTEN, 32'h0);
        chk("irq gen off", irq, 1'b0);
    endtask
    task automatic t_gate;
        for (int m = 0; m < 16; m++) begin
            db <= (m < 8) ? 2'b01 : 2'b10;
            apb(1'b1, pmoc_pkg::OFF_ENABLE, {30'h0, 2'(m)});
            apb(1'b1, pmoc_pkg::OFF_INVERT, {30'h0, 2'(m >> 2)});
            pins((2'(m) & db) ^ 2'(m >> 2));
        end
    endtask
    task automatic t_fault;
        db <= 2'b11;
        apb(1'b1, pmoc_pkg::OFF_ENABLE, 32'h3);
        apb(1'b1, pmoc_pkg::OFF_INVERT, 32'h1);
        apb(1'b1, pmoc_pkg::OFF_FAULT, 32'h1);
        apb(1'b1, pmoc_pkg::OFF_INTEN, 32'h0001_0000);
        trip <= 1'b1;
        pins(2'b11);
        chk("fault", fault_cond, 1'b1);
        rchk("status", pmoc_pkg::OFF_STATUS, 32'h1);
        trip <= 1'b0;
        pins(2'b10);
        rchk("status", pmoc_pkg::OFF_STATUS, '0);
        rchk("latched", pmoc_pkg::OFF_RIS, 32'h0001_0000);
        chk("irq", irq, 1'b1);
        apb(1'b1, pmoc_pkg::OFF_ISC, 32'h0001_0000);
        rchk("cleared", pmoc_pkg::OFF_ISC, '0);
        chk("irq", irq, 1'b0);
        debug_stall <= 1'b1;
        pins(2'b11);
        rchk("stall no int", pmoc_pkg::OFF_RIS, '0);
        debug_stall <= 1'b0;
        pins(2'b10);
    endtask
    task automatic t_sync;
        apb(1'b1, pmoc_pkg::OFF_SYNC, 32'h1);
        #1 chk("resync", cnt_rst, 1'b1);
        @(posedge clk);
        #1 chk("resync end", cnt_rst, 1'b0);
        rchk("sync", pmoc_pkg::OFF_SYNC, '0);
    endtask
    task automatic t_update;
        zero(1'b0);
        apb(1'b1, pmoc_pkg::OFF_CTL, 32'h1);
        apb(1'b1, pmoc_pkg::OFF_CTL, 32'h0);
        rchk("update", pmoc_pkg::OFF_CTL, 32'h1);
        zero(1'b1);
        rchk("update done", pmoc_pkg::OFF_CTL, '0);
    endtask
    task automatic conclude;
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_bus;
        t_gate;
        t_fault;
        t_sync;
        t_update;
        conclude;
    end
    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude;
        end
    end
endmodule
